//--- cap_regs_pkg.sv
// Purpose: constants for the per-port device and link capability registers
// Assumes: 32-bit configuration words, one port per instance
// Notes:   offsets are byte addresses of configuration space
package cap_regs_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [11:0] DEV_CAP_OFFSET    = 12'h06C;
    localparam logic [11:0] DEV_STSCTL_OFFSET = 12'h070;
    localparam logic [11:0] LINK_CAP_OFFSET   = 12'h074;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int SPL_VALUE_LSB = 18;
    localparam int SPL_SCALE_LSB = 26;
    localparam int ERR_EN_LSB    = 0;
    localparam int MPS_LSB       = 5;
    localparam int ERR_DET_LSB   = 16;
    localparam int SPEED_LSB     = 0;
    localparam int WIDTH_LSB     = 4;
    localparam int ASPM_LSB      = 10;

    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [7:0] SPL_VALUE_RESET = 8'h00;
    localparam logic [1:0] SPL_SCALE_RESET = 2'h0;
    localparam logic [3:0] ERR_EN_RESET    = 4'h0;
    localparam logic [2:0] MPS_RESET       = 3'h0;
    localparam logic [2:0] MPS_MAX_CODE    = 3'h4;
    localparam logic [3:0] SPEED_GEN2      = 4'h2;
    localparam logic [3:0] SPEED_GEN1      = 4'h1;
    localparam logic [5:0] WIDTH_X1        = 6'h01;
    localparam logic [1:0] ASPM_RESET      = 2'h3;
    localparam logic [1:0] ASPM_L0S_ONLY   = 2'h1;

    // scale code meaning, in thousandths of a watt multiplier
    localparam logic [9:0] SCALE_MILLI [4] = '{10'd1000, 10'd100,
                                               10'd10, 10'd1};

endpackage

//--- preset_if.sv
`timescale 1ns/1ps
// Purpose: carries eeprom or i2c preset writes between design modules
// Assumes: one word written per valid cycle
// Notes:   mask selects which bits of the word are replaced
interface preset_if;
    logic        valid;
    logic [11:0] offset;
    logic [31:0] data;
    logic [31:0] mask;

    modport source (output valid, offset, data, mask);
    modport sink   (input  valid, offset, data, mask);
endinterface

//--- preset_port.sv
`timescale 1ns/1ps
// Purpose: registers an eeprom or i2c preset write for the register bank
// Assumes: loader pulses load_valid once per word
// Notes:   one cycle of latency, kept so decode sees clean values
module preset_port
    import cap_regs_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // loader side
    input  wire logic        load_valid,
    input  wire logic [11:0] load_offset,
    input  wire logic [31:0] load_data,
    input  wire logic [31:0] load_mask,
    // bank side
    preset_if.source         preset
);

    typedef struct packed {
        logic        valid;
        logic [11:0] offset;
        logic [31:0] data;
        logic [31:0] mask;
    } state_type;

    state_type state_reg;
    state_type state_next;

    // capture the loader word
    always_comb begin
        state_next        = state_reg;
        state_next.valid  = load_valid;
        state_next.offset = load_offset;
        state_next.data   = load_data;
        state_next.mask   = load_mask;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign preset.valid  = state_reg.valid;
    assign preset.offset = state_reg.offset;
    assign preset.data   = state_reg.data;
    assign preset.mask   = state_reg.mask;

endmodule // preset_port

//--- slot_power_decode.sv
`timescale 1ns/1ps
// Purpose: turns captured slot power value and scale into milliwatts
// Assumes: scale is the two-bit captured code
// Notes:   result registered; max 255 W fits 18 bits
module slot_power_decode
    import cap_regs_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // captured fields
    input  wire logic [7:0]  value,
    input  wire logic [1:0]  scale,
    // decoded limit
    output logic      [17:0] milliwatts
);

    typedef struct packed {
        logic [17:0] mw;
    } state_type;

    state_type state_reg;
    state_type state_next;

    // value times scale factor in thousandths
    always_comb begin
        state_next    = state_reg;
        state_next.mw = 18'(value) * 18'(SCALE_MILLI[scale]);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign milliwatts = state_reg.mw;

endmodule // slot_power_decode

//--- cap_regs.sv
`timescale 1ns/1ps
// Purpose: device capability, device status/control, link capability
// Assumes: configuration write/read strobes synchronous to clock
// Notes:   read data registered one cycle after the read strobe
module cap_regs
    import cap_regs_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        arst_n,
    // port role and straps
    input  wire logic        upstream_port,
    input  wire logic        speed_select_strap,
    input  wire logic [5:0]  station_port_config_straps,
    // configuration access
    input  wire logic        cfg_write,
    input  wire logic        cfg_read,
    input  wire logic [11:0] cfg_offset,
    input  wire logic [3:0]  cfg_byte_en,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_rvalid,
    // eeprom or i2c preset
    input  wire logic        load_valid,
    input  wire logic [11:0] load_offset,
    input  wire logic [31:0] load_data,
    input  wire logic [31:0] load_mask,
    // slot power captured from the set slot power limit message
    input  wire logic        spl_capture,
    input  wire logic [7:0]  spl_value_in,
    input  wire logic [1:0]  spl_scale_in,
    // error events, one-cycle pulses
    input  wire logic [3:0]  err_detect,
    // block state out
    output logic      [3:0]  err_report_en,
    output logic      [2:0]  max_payload,
    output logic      [3:0]  err_detected,
    output logic      [5:0]  max_link_width,
    output logic      [17:0] slot_power_mw
);

    preset_if preset ();

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic        started;
        logic [7:0]  spl_value;
        logic [1:0]  spl_scale;
        logic [3:0]  err_en;
        logic [2:0]  mps;
        logic [3:0]  err_det;
        logic [3:0]  speeds;
        logic [5:0]  width;
        logic [1:0]  aspm;
        logic [31:0] rdata;
        logic        rvalid;
    } state_type;

    state_type   state_reg;
    state_type   state_next;
    logic [31:0] wmask;
    logic [31:0] dev_cap_word;
    logic [31:0] stsctl_word;
    logic [31:0] link_cap_word;

    preset_port u_preset (
        .clock       (clock),
        .arst_n      (arst_n),
        .load_valid  (load_valid),
        .load_offset (load_offset),
        .load_data   (load_data),
        .load_mask   (load_mask),
        .preset      (preset)
    );

    slot_power_decode u_spl (
        .clock      (clock),
        .arst_n     (arst_n),
        .value      (state_reg.spl_value),
        .scale      (state_reg.spl_scale),
        .milliwatts (slot_power_mw)
    );

    // byte enables widened to a bit mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{cfg_byte_en[i]}};
        end
    end

    // ************************************************************
    // read views; every unlisted bit is zero
    // ************************************************************
    always_comb begin
        dev_cap_word = '0;
        if (upstream_port) begin
            dev_cap_word[SPL_VALUE_LSB +: 8] = state_reg.spl_value;
            dev_cap_word[SPL_SCALE_LSB +: 2] = state_reg.spl_scale;
        end
        // control bits 4, 8..15 and status 20, 21 stay zero
        stsctl_word = '0;
        stsctl_word[ERR_EN_LSB +: 4]  = state_reg.err_en;
        stsctl_word[MPS_LSB +: 3]     = state_reg.mps;
        stsctl_word[ERR_DET_LSB +: 4] = state_reg.err_det;
        link_cap_word = '0;
        link_cap_word[SPEED_LSB +: 4] = state_reg.speeds;
        link_cap_word[WIDTH_LSB +: 6] = state_reg.width;
        link_cap_word[ASPM_LSB +: 2]  = state_reg.aspm;
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        state_next.started = 1'b1;
        // straps are caught on the first clock after reset release
        if (!state_reg.started) begin
            state_next.speeds = speed_select_strap ? SPEED_GEN2
                                                   : SPEED_GEN1;
            state_next.width  = station_port_config_straps;
        end

        // eeprom/i2c preset; only loadable fields are touched
        if (preset.valid) begin
            if (preset.offset == DEV_CAP_OFFSET) begin
                for (int b = 0; b < 8; b++) begin
                    if (preset.mask[SPL_VALUE_LSB + b])
                        state_next.spl_value[b] =
                            preset.data[SPL_VALUE_LSB + b];
                end
                for (int b = 0; b < 2; b++) begin
                    if (preset.mask[SPL_SCALE_LSB + b])
                        state_next.spl_scale[b] =
                            preset.data[SPL_SCALE_LSB + b];
                end
            end else if (preset.offset == DEV_STSCTL_OFFSET) begin
                for (int b = 0; b < 4; b++) begin
                    if (preset.mask[ERR_EN_LSB + b])
                        state_next.err_en[b] = preset.data[ERR_EN_LSB + b];
                end
                if (preset.mask[MPS_LSB +: 3] == 3'h7 &&
                    preset.data[MPS_LSB +: 3] <= MPS_MAX_CODE)
                    state_next.mps = preset.data[MPS_LSB +: 3];
            end else if (preset.offset == LINK_CAP_OFFSET) begin
                // reserved speed codes are never loaded
                if (preset.mask[SPEED_LSB +: 4] == 4'hF &&
                    (preset.data[SPEED_LSB +: 4] == SPEED_GEN1 ||
                     preset.data[SPEED_LSB +: 4] == SPEED_GEN2))
                    state_next.speeds = preset.data[SPEED_LSB +: 4];
                // width is the eeprom port configuration value
                if (preset.mask[WIDTH_LSB +: 6] == 6'h3F &&
                    $onehot(preset.data[WIDTH_LSB +: 6]))
                    state_next.width = preset.data[WIDTH_LSB +: 6];
                // only 01b and 11b are legal; both have the low bit set
                if (preset.mask[ASPM_LSB +: 2] == 2'h3 &&
                    preset.data[ASPM_LSB])
                    state_next.aspm = preset.data[ASPM_LSB +: 2];
            end
        end

        // captured slot power from the link, upstream only
        if (spl_capture && upstream_port) begin
            state_next.spl_value = spl_value_in;
            state_next.spl_scale = spl_scale_in;
        end

        // configuration writes: only control bits and write-1-clear
        if (cfg_write && cfg_offset == DEV_STSCTL_OFFSET) begin
            if (cfg_byte_en[0]) begin
                state_next.err_en = cfg_wdata[ERR_EN_LSB +: 4];
                // out of range codes ignored, field keeps its value
                if (cfg_wdata[MPS_LSB +: 3] <= MPS_MAX_CODE)
                    state_next.mps = cfg_wdata[MPS_LSB +: 3];
            end
            state_next.err_det = state_next.err_det &
                ~(cfg_wdata[ERR_DET_LSB +: 4] &
                  wmask[ERR_DET_LSB +: 4]);
        end

        // detection wins over a same-cycle clear; enables ignored
        state_next.err_det = state_next.err_det | err_detect;

        // registered read data, unmapped offsets read zero
        state_next.rvalid = cfg_read;
        if (!cfg_read) begin
            state_next.rdata = state_reg.rdata;
        end else if (cfg_offset == DEV_CAP_OFFSET) begin
            state_next.rdata = dev_cap_word;
        end else if (cfg_offset == DEV_STSCTL_OFFSET) begin
            state_next.rdata = stsctl_word;
        end else if (cfg_offset == LINK_CAP_OFFSET) begin
            state_next.rdata = link_cap_word;
        end else begin
            state_next.rdata = '0;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg           <= '0;
            state_reg.spl_value <= SPL_VALUE_RESET;
            state_reg.spl_scale <= SPL_SCALE_RESET;
            state_reg.err_en    <= ERR_EN_RESET;
            state_reg.mps       <= MPS_RESET;
            state_reg.speeds    <= SPEED_GEN1;
            state_reg.width     <= WIDTH_X1;
            state_reg.aspm      <= ASPM_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cfg_rdata      = state_reg.rdata;
    assign cfg_rvalid     = state_reg.rvalid;
    assign err_report_en  = state_reg.err_en;
    assign max_payload    = state_reg.mps;
    assign err_detected   = state_reg.err_det;
    assign max_link_width = state_reg.width;

    // ************************************************************
    // checks
    // ************************************************************
    err_sticky_a: assert property (@(posedge clock)
        disable iff (!arst_n) err_detect[0] |=> err_detected[0])
        else $error("error flag not set");
    err_clear_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        cfg_write && cfg_offset == DEV_STSCTL_OFFSET && cfg_byte_en[2] &&
        cfg_wdata[ERR_DET_LSB] && !err_detect[0] |=> !err_detected[0])
        else $error("error flag not cleared");
    mps_range_a: assert property (@(posedge clock)
        disable iff (!arst_n) max_payload <= MPS_MAX_CODE)
        else $error("payload code out of range");
    downstream_spl_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        cfg_read && cfg_offset == DEV_CAP_OFFSET && !upstream_port
        |=> cfg_rdata[31:18] == '0)
        else $error("slot power visible downstream");
    ctl_rsvd_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        cfg_read && cfg_offset == DEV_STSCTL_OFFSET
        |=> cfg_rdata[15:8] == '0 && !cfg_rdata[4] && cfg_rdata[21:20] == '0)
        else $error("reserved control bits set");
    en_write_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        cfg_write && cfg_offset == DEV_STSCTL_OFFSET && cfg_byte_en[0]
        |=> err_report_en == $past(cfg_wdata[3:0]))
        else $error("reporting enables not written");
    speed_strap_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        $rose(state_reg.started) && !$past(preset.valid)
        |-> state_reg.speeds == ($past(speed_select_strap) ? SPEED_GEN2
                                                          : SPEED_GEN1))
        else $error("speed default not from strap");
    read_valid_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        cfg_read && cfg_offset == LINK_CAP_OFFSET
        |=> cfg_rvalid && cfg_rdata[31:12] == '0)
        else $error("link capability reserved bits set");

    // ************************************************************
    // reset, strap, read-only field and error flag checks
    // ************************************************************
    rst_zero_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        $rose(state_reg.started)
        |-> $past(err_report_en) == '0 && $past(max_payload) == '0)
        else $error("control not zero after reset");
    aspm_reset_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        $rose(state_reg.started) |-> $past(state_reg.aspm) == ASPM_RESET)
        else $error("link power support not reset to both");
    width_strap_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        $rose(state_reg.started) && !$past(preset.valid)
        |-> max_link_width == $past(station_port_config_straps))
        else $error("link width not from straps");
    speed_legal_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        state_reg.speeds == SPEED_GEN1 || state_reg.speeds == SPEED_GEN2)
        else $error("reserved link speed code");
    aspm_legal_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        state_reg.aspm == ASPM_RESET || state_reg.aspm == ASPM_L0S_ONLY)
        else $error("reserved link power code");
    ro_write_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        cfg_write && cfg_offset == LINK_CAP_OFFSET && state_reg.started &&
        !preset.valid |=> $stable(max_link_width))
        else $error("link width written by software");
    upstream_spl_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        cfg_read && cfg_offset == DEV_CAP_OFFSET && upstream_port
        |=> cfg_rdata[27:18] ==
            $past({state_reg.spl_scale, state_reg.spl_value}))
        else $error("captured slot power not shown upstream");
    spl_ignore_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        spl_capture && !upstream_port && !preset.valid
        |=> $stable(state_reg.spl_value))
        else $error("slot power captured downstream");
    det_all_a: assert property (@(posedge clock)
        disable iff (!arst_n)
        err_detect != '0
        |=> (err_detected & $past(err_detect)) == $past(err_detect))
        else $error("detected flag missed an event");

endmodule // cap_regs

//--- cap_regs_tb.sv
// Purpose: self-checking bench for the per-port capability registers
// Assumes: 50 MHz clock, config strobes driven as one-cycle pulses
// Notes:   only bits owned by this block are compared in 6C and 74
`timescale 1ns/1ps
module cap_regs_tb
    import cap_regs_pkg::*;
;
    // clock and reset
    logic        clock;
    logic        arst_n;
    // straps and role
    logic        upstream_port;
    logic        speed_select_strap;
    logic [5:0]  station_port_config_straps;
    // configuration access
    logic        cfg_write;
    logic        cfg_read;
    logic [11:0] cfg_offset;
    logic [3:0]  cfg_byte_en;
    logic [31:0] cfg_wdata;
    logic [31:0] cfg_rdata;
    logic        cfg_rvalid;
    // preset, slot power and error events
    logic        load_valid;
    logic [11:0] load_offset;
    logic [31:0] load_data;
    logic [31:0] load_mask;
    logic        spl_capture;
    logic [7:0]  spl_value_in;
    logic [1:0]  spl_scale_in;
    logic [3:0]  err_detect;
    // block state
    logic [3:0]  err_report_en;
    logic [2:0]  max_payload;
    logic [3:0]  err_detected;
    logic [5:0]  max_link_width;
    logic [17:0] slot_power_mw;
    int          mismatches;
    int          check_count;
    logic [31:0] rd;

    cap_regs uut (
        .clock(clock), .arst_n(arst_n), .upstream_port(upstream_port),
        .speed_select_strap(speed_select_strap),
        .station_port_config_straps(station_port_config_straps),
        .cfg_write(cfg_write), .cfg_read(cfg_read),
        .cfg_offset(cfg_offset), .cfg_byte_en(cfg_byte_en),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .load_valid(load_valid),
        .load_offset(load_offset), .load_data(load_data),
        .load_mask(load_mask), .spl_capture(spl_capture),
        .spl_value_in(spl_value_in), .spl_scale_in(spl_scale_in),
        .err_detect(err_detect), .err_report_en(err_report_en),
        .max_payload(max_payload), .err_detected(err_detected),
        .max_link_width(max_link_width), .slot_power_mw(slot_power_mw)
    );

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_level(input logic [17:0] got,
                             input logic [17:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // strobe lowered one edge later, so back-to-back calls never collide
    task automatic cfg_wr(input logic [11:0] off, input logic [3:0] be,
                          input logic [31:0] d);
        @(posedge clock);
        cfg_write   <= 1'b1;
        cfg_offset  <= off;
        cfg_byte_en <= be;
        cfg_wdata   <= d;
        @(posedge clock);
        cfg_write   <= 1'b0;
    endtask

    task automatic cfg_rd(input logic [11:0] off, output logic [31:0] d);
        @(posedge clock);
        cfg_read   <= 1'b1;
        cfg_offset <= off;
        @(posedge clock);
        cfg_read   <= 1'b0;
        #1;
        chk_level({17'h0, cfg_rvalid}, 18'h1);
        d = cfg_rdata;
    endtask

    task automatic preset(input logic [11:0] off, input logic [31:0] d,
                          input logic [31:0] m);
        @(posedge clock);
        load_valid  <= 1'b1;
        load_offset <= off;
        load_data   <= d;
        load_mask   <= m;
        @(posedge clock);
        load_valid  <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask

    // straps stay static across the release, sampled on its first edge
    task automatic apply_reset(input logic up, input logic spd,
                               input logic [5:0] w);
        @(posedge clock);
        arst_n                     <= 1'b0;
        upstream_port              <= up;
        speed_select_strap         <= spd;
        station_port_config_straps <= w;
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic test_reset_upstream();
        #1;
        chk_level({14'h0, err_report_en}, 18'h0);
        chk_level({15'h0, max_payload}, 18'h0);
        chk_level({12'h0, max_link_width}, 18'h08);
        cfg_rd(DEV_CAP_OFFSET, rd);
        chk_word(rd & 32'hFFFF_0000, 32'h0);
        cfg_rd(DEV_STSCTL_OFFSET, rd);
        chk_word(rd, 32'h0);
        cfg_rd(LINK_CAP_OFFSET, rd);
        chk_word(rd & 32'h0000_0FFF, 32'h0000_0C82);
    endtask

    task automatic test_errors();
        @(posedge clock);
        err_detect <= 4'hF;
        @(posedge clock);
        err_detect <= 4'h0;
        #1;
        chk_level({14'h0, err_detected}, 18'hF);
        cfg_rd(DEV_STSCTL_OFFSET, rd);
        chk_word(rd, 32'h000F_0000);
        cfg_wr(DEV_STSCTL_OFFSET, 4'hB, 32'h000F_0000);
        cfg_wr(DEV_STSCTL_OFFSET, 4'h4, 32'h0005_00FF);
        cfg_rd(DEV_STSCTL_OFFSET, rd);
        chk_word(rd, 32'h000A_0000);
        // set and clear on the same edge: the new event must win
        @(posedge clock);
        err_detect  <= 4'h2;
        cfg_write   <= 1'b1;
        cfg_byte_en <= 4'h4;
        cfg_wdata   <= 32'h000A_0000;
        @(posedge clock);
        err_detect  <= 4'h0;
        cfg_write   <= 1'b0;
        #1;
        chk_level({14'h0, err_detected}, 18'h2);
        cfg_wr(DEV_STSCTL_OFFSET, 4'h4, 32'h0002_0000);
        cfg_rd(DEV_STSCTL_OFFSET, rd);
        chk_word(rd, 32'h0);
    endtask

    task automatic test_control();
        cfg_wr(DEV_STSCTL_OFFSET, 4'h1, 32'h0000_008F);
        cfg_wr(DEV_STSCTL_OFFSET, 4'hF, 32'hFFC0_FF9F);
        cfg_rd(DEV_STSCTL_OFFSET, rd);
        chk_word(rd, 32'h0000_008F);
        chk_level({14'h0, err_report_en}, 18'hF);
        chk_level({15'h0, max_payload}, 18'h4);
        cfg_wr(DEV_CAP_OFFSET, 4'hF, 32'hFFFF_FFFF);
        cfg_wr(LINK_CAP_OFFSET, 4'hF, 32'hFFFF_FFFF);
        cfg_rd(DEV_CAP_OFFSET, rd);
        chk_word(rd & 32'hFFFF_0000, 32'h0);
        cfg_rd(LINK_CAP_OFFSET, rd);
        chk_word(rd & 32'h0000_0FFF, 32'h0000_0C82);
        cfg_rd(12'h078, rd);
        chk_word(rd, 32'h0);
    endtask

    task automatic test_slot_power();
        logic [9:0] milli [4];
        milli = '{10'd1000, 10'd100, 10'd10, 10'd1};
        for (int s = 0; s < 4; s++) begin
            @(posedge clock);
            spl_capture  <= 1'b1;
            spl_value_in <= 8'hC8;
            spl_scale_in <= 2'(s);
            @(posedge clock);
            spl_capture  <= 1'b0;
            repeat (2) @(posedge clock);
            #1;
            chk_level(slot_power_mw, 18'(200 * milli[s]));
            cfg_rd(DEV_CAP_OFFSET, rd);
            chk_word(rd >> 16, {20'h0, 2'(s), 8'hC8, 2'h0});
        end
    endtask

    task automatic test_preset();
        preset(DEV_STSCTL_OFFSET, 32'h0000_1F63, 32'hFFFF_FFFF);
        chk_level({15'h0, max_payload}, 18'h3);
        cfg_rd(DEV_STSCTL_OFFSET, rd);
        chk_word(rd, 32'h0000_0063);
        preset(LINK_CAP_OFFSET, 32'h0000_0440, 32'h0000_0FF0);
        chk_level({12'h0, max_link_width}, 18'h04);
        cfg_rd(LINK_CAP_OFFSET, rd);
        chk_word(rd & 32'h0000_0FFF, 32'h0000_0442);
    endtask

    task automatic test_downstream();
        apply_reset(1'b0, 1'b0, 6'h10);
        #1;
        chk_level({12'h0, max_link_width}, 18'h10);
        cfg_rd(LINK_CAP_OFFSET, rd);
        chk_word(rd & 32'h0000_0FFF, 32'h0000_0D01);
        @(posedge clock);
        spl_capture  <= 1'b1;
        spl_value_in <= 8'h5A;
        spl_scale_in <= 2'h2;
        @(posedge clock);
        spl_capture  <= 1'b0;
        cfg_rd(DEV_CAP_OFFSET, rd);
        chk_word(rd & 32'hFFFF_0000, 32'h0);
    endtask

    // ************************************************************
    // clock, watchdog and main sequence
    // ************************************************************
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // whole run is about a hundred cycles; this bound is generous
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        mismatches = 0;
        check_count = 0;
        arst_n = 1'b0;
        upstream_port = 1'b1;
        speed_select_strap = 1'b1;
        station_port_config_straps = 6'h08;
        cfg_write = 1'b0;
        cfg_read = 1'b0;
        cfg_offset = 12'h000;
        cfg_byte_en = 4'h0;
        cfg_wdata = 32'h0;
        load_valid = 1'b0;
        load_offset = 12'h000;
        load_data = 32'h0;
        load_mask = 32'h0;
        spl_capture = 1'b0;
        spl_value_in = 8'h00;
        spl_scale_in = 2'h0;
        err_detect = 4'h0;
        apply_reset(1'b1, 1'b1, 6'h08);
        test_reset_upstream();
        test_errors();
        test_control();
        test_slot_power();
        test_preset();
        test_downstream();
        tally_and_finish();
    end
endmodule // cap_regs_tb
